/* File: design/cpc_pkg.sv */
// constants shared by the cascaded interrupt controller pair
// assumes a byte-wide host i/o port and one 100 MHz clock
package cpc_pkg;
	// io port addresses of the two controllers
	localparam logic [15:0] MASTER_CMD_ADDR = 16'h0020;
	localparam logic [15:0] MASTER_DATA_ADDR = 16'h0021;
	localparam logic [15:0] SLAVE_CMD_ADDR = 16'h00A0;
	localparam logic [15:0] SLAVE_DATA_ADDR = 16'h00A1;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// command port and vector word field positions
	localparam int INIT_SEL_BIT = 4;
	localparam int READ_SEL_BIT = 3;
	localparam int CMD_LSB = 5;
	localparam int CMD_W = 3;
	localparam int LEVEL_LSB = 0;
	localparam int LEVEL_W = 3;
	localparam int VBASE_LSB = 3;
	localparam int VBASE_W = 5;

	// init word four fields
	localparam int SPECIAL_NESTED_BIT = 4;
	localparam int AUTO_EOI_BIT = 1;

	// reset values
	localparam logic [7:0] INIT4_RESET = 8'h01;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] LINES_CLEAR = 8'h00;
	localparam logic [2:0] LOWEST_RESET = 3'h7;
	localparam logic [4:0] VBASE_RESET = 5'h00;

	// cascade and spurious lines
	localparam logic [2:0] CASCADE_LINE = 3'h2;
	localparam logic [7:0] CASCADE_ONEHOT = 8'h04;
	localparam logic [2:0] SPURIOUS_LINE = 3'h7;
	localparam logic [7:0] LINE_ONE = 8'h01;

	// rotate and end-of-interrupt command codes
	localparam logic [2:0] CMD_ROT_AUTO_END_OF_INTERRUPT_CLR = 3'h0;
	localparam logic [2:0] CMD_NS_EOI = 3'h1;
	localparam logic [2:0] CMD_NOP = 3'h2;
	localparam logic [2:0] CMD_S_EOI = 3'h3;
	localparam logic [2:0] CMD_ROT_AUTO_END_OF_INTERRUPT_SET = 3'h4;
	localparam logic [2:0] CMD_ROT_NS_EOI = 3'h5;
	localparam logic [2:0] CMD_SET_PRIO = 3'h6;
	localparam logic [2:0] CMD_ROT_S_EOI = 3'h7;

	typedef enum logic [1:0] {
		INIT_READY,
		INIT_WAIT_VECTOR,
		INIT_WAIT_CASCADE,
		INIT_WAIT_MODE
	} cpc_init_type;
endpackage

/* File: design/cpc_prio_find.sv */
// rotating priority search over eight lines
// assumes the line after 'lowest' has top priority
`timescale 1ns/1ns
module cpc_prio_find (
	// lines and rotation point
	input wire logic [7:0] vec,
	input wire logic [2:0] lowest,
	// result
	output logic found,
	output logic [2:0] idx,
	output logic [2:0] rank
);
	always_comb begin
		logic [2:0] pos;
		pos = 3'h0;
		found = 1'b0;
		idx = 3'h0;
		rank = 3'h0;
		// downward walk so the best rank is taken last
		for (int k = 7; k >= 0; k--) begin
			pos = lowest + 3'(k) + 3'h1;
			if (vec[pos]) begin
				found = 1'b1;
				idx = pos;
				rank = 3'(k);
			end
		end
	end
endmodule

/* File: design/cpc_top.sv */
// master and slave interrupt controllers with host i/o port decode
// assumes host strobes are one-cycle pulses on CLK, requests are pins
//
// How it works
// - bit four enables special nested priority
// - bit one enables automatic end of interrupt
// - init word four write-only, default 01h
// - masked line never sets its request bit
// - masking higher line leaves lower lines working
// - data port read returns the mask directly
// - master line two mask blocks slave
// - mask readable, writable, reset to 00h
// - reset or init gives fully nested priority
// - codes 001, 011, 101, 111 end interrupts
// - codes 100, 000 set, clear auto rotation
// - 110 set priority, 111 rotate, 010 nop
// - level field used only by specific commands
// - init start, then three data port words
// - init start clears the mask
// - slave output feeds master request line two
`timescale 1ns/1ns
module cpc_top (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// host i/o port
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [7:0] IO_WDATA,
	output logic [7:0] IO_RDATA,
	// request pins, lines 0-7 master, 8-15 slave
	input wire logic [15:0] IRQ,
	// processor interrupt and acknowledge
	output logic INTR,
	input wire logic INTA_REQ,
	output logic [7:0] VEC,
	output logic VEC_VALID
);
	// request pin synchroniser and edge filter
	logic [15:0] irq_s1;
	logic [15:0] irq_s2;
	logic [15:0] irq_s3;
	logic [15:0] irq_filt;
	wire [15:0] next_filt;
	wire [15:0] irq_rise;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_s1 <= 16'h0000;
			irq_s2 <= 16'h0000;
			irq_s3 <= 16'h0000;
			irq_filt <= 16'h0000;
		end else begin
			irq_s1 <= IRQ;
			irq_s2 <= irq_s1;
			irq_s3 <= irq_s2;
			irq_filt <= next_filt;
		end
	end

	// a level counts once the second and third stage agree
	assign next_filt = (irq_s2 & irq_s3) | (irq_filt & (irq_s2 | irq_s3));
	assign irq_rise = irq_s2 & irq_s3 & ~irq_filt;

	// signals crossing between the two controllers
	wire [1:0] int_req;
	wire [1:0] ack;
	wire [1:0] rd_hit;
	wire [7:0] rd_val [2];
	wire [2:0] grant_idx [2];
	wire [4:0] vbase_w [2];
	wire cascade_grant;

	assign cascade_grant = int_req[0] && (grant_idx[0] == cpc_pkg::CASCADE_LINE);
	assign ack[0] = INTA_REQ;
	assign ack[1] = INTA_REQ && cascade_grant;

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ctl
			localparam logic [15:0] CMD_ADDR =
				(c == 0) ? cpc_pkg::MASTER_CMD_ADDR : cpc_pkg::SLAVE_CMD_ADDR;
			localparam logic [15:0] DATA_ADDR =
				(c == 0) ? cpc_pkg::MASTER_DATA_ADDR : cpc_pkg::SLAVE_DATA_ADDR;
			localparam logic [7:0] CASC_SEL =
				(c == 0) ? cpc_pkg::CASCADE_ONEHOT : cpc_pkg::LINES_CLEAR;

			cpc_pkg::cpc_init_type state;
			cpc_pkg::cpc_init_type next_state;
			logic [7:0] init4;
			logic [7:0] mask;
			logic [7:0] request_pending_register;
			logic [7:0] in_service_register;
			logic [2:0] lowest;
			logic [4:0] vbase;
			logic rot_auto_end_of_interrupt;

			wire sel_cmd;
			wire sel_data;
			wire wr_cmd;
			wire wr_data;
			wire ready;
			wire init_start;
			wire cmd_wr;
			wire [2:0] cmd;
			wire [2:0] level;
			wire [7:0] level_hot;
			wire special_nested;
			wire auto_eoi;
			wire [7:0] pend;
			wire pend_found;
			wire [2:0] pend_idx;
			wire [2:0] pend_rank;
			wire isr_found;
			wire [2:0] isr_idx;
			wire [2:0] isr_rank;
			wire take;
			wire [7:0] take_hot;
			wire ns_eoi;
			wire s_eoi;
			wire set_level;
			wire [7:0] eoi_clr;
			wire [7:0] irr_calc;
			wire casc_level;
			wire [7:0] next_irr;
			wire [7:0] next_isr;
			wire [7:0] next_mask;
			wire [7:0] next_init4;
			wire [4:0] next_vbase;
			wire [2:0] next_lowest;
			wire next_rot_auto_end_of_interrupt;

			// port decode
			assign sel_cmd = IO_ADDR == CMD_ADDR;
			assign sel_data = IO_ADDR == DATA_ADDR;
			assign wr_cmd = IO_WR && sel_cmd;
			assign wr_data = IO_WR && sel_data;
			assign ready = state == cpc_pkg::INIT_READY;
			assign init_start = wr_cmd && IO_WDATA[cpc_pkg::INIT_SEL_BIT];
			// read-select words are taken and ignored
			assign cmd_wr = wr_cmd && ready &&
				!IO_WDATA[cpc_pkg::INIT_SEL_BIT] &&
				!IO_WDATA[cpc_pkg::READ_SEL_BIT];
			assign cmd = IO_WDATA[cpc_pkg::CMD_LSB +: cpc_pkg::CMD_W];
			assign level = IO_WDATA[cpc_pkg::LEVEL_LSB +: cpc_pkg::LEVEL_W];
			assign level_hot = cpc_pkg::LINE_ONE << level;

			// mode bits live in the stored init word four
			assign special_nested = init4[cpc_pkg::SPECIAL_NESTED_BIT];
			assign auto_eoi = init4[cpc_pkg::AUTO_EOI_BIT];

			// masked lines drop out of the search and are cleared from the request register
			assign pend = request_pending_register & ~mask;

			cpc_prio_find u_pend (
				.vec(pend),
				.lowest(lowest),
				.found(pend_found),
				.idx(pend_idx),
				.rank(pend_rank)
			);

			cpc_prio_find u_serv (
				.vec(in_service_register),
				.lowest(lowest),
				.found(isr_found),
				.idx(isr_idx),
				.rank(isr_rank)
			);

			// nested priority; special mode lets equal rank through
			assign int_req[c] = ready && pend_found && (!isr_found ||
				(pend_rank < isr_rank) ||
				(special_nested && (pend_rank == isr_rank)));

			// acknowledge
			assign take = ack[c] && int_req[c];
			assign take_hot = take ? (cpc_pkg::LINE_ONE << pend_idx) :
				cpc_pkg::LINES_CLEAR;
			assign grant_idx[c] = int_req[c] ? pend_idx : cpc_pkg::SPURIOUS_LINE;
			assign vbase_w[c] = vbase;

			// rotate and end-of-interrupt command decode
			assign ns_eoi = cmd_wr && isr_found &&
				((cmd == cpc_pkg::CMD_NS_EOI) ||
				(cmd == cpc_pkg::CMD_ROT_NS_EOI));
			assign s_eoi = cmd_wr && ((cmd == cpc_pkg::CMD_S_EOI) ||
				(cmd == cpc_pkg::CMD_ROT_S_EOI));
			assign set_level = cmd_wr && ((cmd == cpc_pkg::CMD_SET_PRIO) ||
				(cmd == cpc_pkg::CMD_ROT_S_EOI));
			assign eoi_clr =
				(ns_eoi ? (cpc_pkg::LINE_ONE << isr_idx) : cpc_pkg::LINES_CLEAR) |
				(s_eoi ? level_hot : cpc_pkg::LINES_CLEAR);

			// edge requests, cascade line follows the slave level
			assign casc_level = (c == 0) ? int_req[1] : 1'b0;
			assign irr_calc = (((request_pending_register & ~take_hot) | irq_rise[c*8 +: 8]) &
				~CASC_SEL) | (CASC_SEL & {8{casc_level}});
			assign next_irr = init_start ? cpc_pkg::LINES_CLEAR :
				irr_calc & ~mask;

			// new service bit wins over a clear in the same cycle
			assign next_isr = init_start ? cpc_pkg::LINES_CLEAR :
				(in_service_register & ~eoi_clr) |
				(auto_eoi ? cpc_pkg::LINES_CLEAR : take_hot);

			assign next_mask = init_start ? cpc_pkg::MASK_RESET :
				(wr_data && ready) ? IO_WDATA : mask;

			assign next_init4 = init_start ? cpc_pkg::INIT4_RESET :
				(wr_data && (state == cpc_pkg::INIT_WAIT_MODE)) ?
				IO_WDATA : init4;

			assign next_vbase = (wr_data &&
				(state == cpc_pkg::INIT_WAIT_VECTOR)) ?
				IO_WDATA[cpc_pkg::VBASE_LSB +: cpc_pkg::VBASE_W] : vbase;

			assign next_lowest = init_start ? cpc_pkg::LOWEST_RESET :
				(ns_eoi && (cmd == cpc_pkg::CMD_ROT_NS_EOI)) ? isr_idx :
				set_level ? level :
				(take && auto_eoi && rot_auto_end_of_interrupt) ? pend_idx : lowest;

			assign next_rot_auto_end_of_interrupt = init_start ? 1'b0 :
				(cmd_wr && (cmd == cpc_pkg::CMD_ROT_AUTO_END_OF_INTERRUPT_SET)) ? 1'b1 :
				(cmd_wr && (cmd == cpc_pkg::CMD_ROT_AUTO_END_OF_INTERRUPT_CLR)) ? 1'b0 :
				rot_auto_end_of_interrupt;

			// init word sequencing
			always_comb begin
				next_state = state;
				case (state)
				cpc_pkg::INIT_WAIT_VECTOR: begin
					if (wr_data) begin
						next_state = cpc_pkg::INIT_WAIT_CASCADE;
					end
				end
				cpc_pkg::INIT_WAIT_CASCADE: begin
					if (wr_data) begin
						next_state = cpc_pkg::INIT_WAIT_MODE;
					end
				end
				cpc_pkg::INIT_WAIT_MODE: begin
					if (wr_data) begin
						next_state = cpc_pkg::INIT_READY;
					end
				end
				cpc_pkg::INIT_READY: begin
					next_state = cpc_pkg::INIT_READY;
				end
				default: begin
					next_state = cpc_pkg::INIT_READY;
				end
				endcase
				if (init_start) begin
					next_state = cpc_pkg::INIT_WAIT_VECTOR;
				end
			end

			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					state <= cpc_pkg::INIT_READY;
					init4 <= cpc_pkg::INIT4_RESET;
					mask <= cpc_pkg::MASK_RESET;
					request_pending_register <= cpc_pkg::LINES_CLEAR;
					in_service_register <= cpc_pkg::LINES_CLEAR;
					lowest <= cpc_pkg::LOWEST_RESET;
					vbase <= cpc_pkg::VBASE_RESET;
					rot_auto_end_of_interrupt <= 1'b0;
				end else begin
					state <= next_state;
					init4 <= next_init4;
					mask <= next_mask;
					request_pending_register <= next_irr;
					in_service_register <= next_isr;
					lowest <= next_lowest;
					vbase <= next_vbase;
					rot_auto_end_of_interrupt <= next_rot_auto_end_of_interrupt;
				end
			end

			// data port reads the mask, command port the requests
			assign rd_hit[c] = sel_data || sel_cmd;
			assign rd_val[c] = sel_data ? mask : request_pending_register;
		end
	endgenerate

	wire [7:0] next_rdata;
	wire [7:0] next_vec;

	assign next_rdata = rd_hit[0] ? rd_val[0] :
		rd_hit[1] ? rd_val[1] : cpc_pkg::UNMAPPED_READ;
	assign next_vec = cascade_grant ? {vbase_w[1], grant_idx[1]} :
		{vbase_w[0], grant_idx[0]};

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			IO_RDATA <= cpc_pkg::UNMAPPED_READ;
			INTR <= 1'b0;
			VEC <= 8'h00;
			VEC_VALID <= 1'b0;
		end else begin
			if (IO_RD) begin
				IO_RDATA <= next_rdata;
			end
			INTR <= int_req[0];
			VEC_VALID <= INTA_REQ;
			if (INTA_REQ) begin
				VEC <= next_vec;
			end
		end
	end
endmodule

/* File: tb/cpc_monitor.sv */
// port checker for the cascaded interrupt controller pair
// assumes one clock; bound to every cpc_top instance
`timescale 1ns/1ns
module cpc_monitor (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// host port
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [7:0] IO_WDATA,
	input wire logic [7:0] IO_RDATA,
	// interrupt side
	input wire logic [15:0] IRQ,
	input wire logic INTR,
	input wire logic INTA_REQ,
	input wire logic [7:0] VEC,
	input wire logic VEC_VALID
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire mapped = IO_ADDR[15:8] == 8'h00 && IO_ADDR[6:1] == 6'h10;
	wire init_go = IO_WR && IO_ADDR == cpc_pkg::MASTER_CMD_ADDR &&
		IO_WDATA[cpc_pkg::INIT_SEL_BIT];
	property p_rd_hold;
		!IO_RD |=> $stable(IO_RDATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
	property p_unmapped;
		IO_RD && !mapped |=> IO_RDATA == cpc_pkg::UNMAPPED_READ;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_ack_answer;
		INTA_REQ |=> VEC_VALID;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("no vec");
	property p_valid_cause;
		VEC_VALID |-> $past(INTA_REQ);
	endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("stray vector");
	property p_valid_pulse;
		VEC_VALID && !INTA_REQ |=> !VEC_VALID;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("long valid");
	property p_vec_hold;
		!INTA_REQ |=> $stable(VEC);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
	property p_init_quiet;
		init_go |-> ##2 !INTR [*2];
	endproperty
	a_init_quiet: assert property (p_init_quiet) else $error("init int");
	property p_init_mask;
		init_go ##2 (IO_RD && IO_ADDR == cpc_pkg::MASTER_DATA_ADDR) |=>
			IO_RDATA == cpc_pkg::MASK_RESET;
	endproperty
	a_init_mask: assert property (p_init_mask) else $error("mask kept");
endmodule
bind cpc_top cpc_monitor cpc_monitor_inst (.CLK(CLK), .SYS_RST(SYS_RST),
	.IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA),
	.IO_RDATA(IO_RDATA), .IRQ(IRQ), .INTR(INTR), .INTA_REQ(INTA_REQ),
	.VEC(VEC), .VEC_VALID(VEC_VALID));

/* File: tb/cpc_host.sv */
// host processor model issuing byte i/o cycles
// assumes strobes are taken on the rising edge of clk
`timescale 1ns/1ns
module cpc_host (
	// clock
	input wire logic clk,
	// host port
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata
);
	initial begin
		io_addr = 16'hFFFF;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'hFF;
	end
	// idle bus shows the inverse of the last cycle
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
		io_addr = ~a;
		d = io_rdata;
	endtask
	// mode is {special nested, auto eoi}
	task automatic init(input logic [15:0] b, input logic [4:0] vb,
		input logic [1:0] mode);
		wr(b, 8'h11);
		wr(b + 16'h0001, {vb, 3'h0});
		wr(b + 16'h0001, b[7] ? 8'h02 : 8'h04);
		wr(b + 16'h0001, {3'h0, mode[1], 2'h0, mode[0], 1'h1});
	endtask
	task automatic cmd(input logic [15:0] b, input logic [2:0] c,
		input logic [2:0] l);
		wr(b, {c, 2'h0, l});
	endtask
endmodule

/* File: tb/cpc_top_tb.sv */
// self-checking bench for the cascaded controller pair
// assumes the host model drives the i/o port at the falling edge
`timescale 1ns/1ns
module cpc_top_tb;
	localparam logic [15:0] mc = cpc_pkg::MASTER_CMD_ADDR;
	localparam logic [15:0] md = cpc_pkg::MASTER_DATA_ADDR;
	localparam logic [15:0] sc = cpc_pkg::SLAVE_CMD_ADDR;
	localparam logic [15:0] sd = cpc_pkg::SLAVE_DATA_ADDR;
	logic clk, sys_rst, io_wr, io_rd, inta_req, intr, vec_valid;
	logic [15:0] io_addr, irq;
	logic [7:0] io_wdata, io_rdata, vec, r;
	int fail_count = 0;
	int checks = 0;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	cpc_top cpc_top_inst (.CLK(clk), .SYS_RST(sys_rst), .IO_ADDR(io_addr),
		.IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
		.IRQ(irq), .INTR(intr), .INTA_REQ(inta_req), .VEC(vec),
		.VEC_VALID(vec_valid));
	cpc_host cpc_host_inst (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic raise(input logic [15:0] v);
		@(negedge clk);
		irq = 16'h0000;
		repeat (4) @(negedge clk);
		irq = v;
	endtask
	task automatic quiet;
		repeat (8) @(negedge clk);
		chk({7'h00, intr}, 8'h00);
	endtask
	task automatic ack(input logic [7:0] v);
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		while (intr !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		inta_req = 1'b1;
		@(negedge clk);
		inta_req = 1'b0;
		chk({7'h00, vec_valid}, 8'h01);
		chk(vec, v);
	endtask
	task automatic t_reset;
		cpc_host_inst.rd(md, r);
		chk(r, cpc_pkg::MASK_RESET);
		cpc_host_inst.rd(sd, r);
		chk(r, cpc_pkg::MASK_RESET);
		cpc_host_inst.rd(16'h0022, r);
		chk(r, cpc_pkg::UNMAPPED_READ);
		raise(16'h0008);
		ack(8'h03);
		raise(16'h0010);
		quiet();
		cpc_host_inst.rd(mc, r);
		chk(r, 8'h10);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
		ack(8'h04);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
	endtask
	task automatic t_init;
		cpc_host_inst.init(mc, 5'h08, 2'h0);
		cpc_host_inst.init(sc, 5'h0E, 2'h0);
		cpc_host_inst.wr(md, 8'hA5);
		cpc_host_inst.rd(md, r);
		chk(r, 8'hA5);
		cpc_host_inst.wr(sd, 8'h3C);
		cpc_host_inst.rd(sd, r);
		chk(r, 8'h3C);
		cpc_host_inst.wr(mc, 8'h11);
		cpc_host_inst.rd(md, r);
		chk(r, cpc_pkg::MASK_RESET);
		cpc_host_inst.init(mc, 5'h08, 2'h0);
		cpc_host_inst.wr(sd, 8'h00);
	endtask
	task automatic t_mask;
		cpc_host_inst.wr(md, 8'h08);
		raise(16'h0028);
		ack(8'h45);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
		cpc_host_inst.wr(md, 8'h00);
		quiet();
		cpc_host_inst.wr(md, cpc_pkg::CASCADE_ONEHOT);
		raise(16'h0400);
		quiet();
		cpc_host_inst.wr(md, 8'h00);
		ack(8'h72);
		cpc_host_inst.cmd(sc, cpc_pkg::CMD_NS_EOI, 3'h0);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
	endtask
	task automatic t_rotate;
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_SET_PRIO, 3'h3);
		raise(16'h0042);
		ack(8'h46);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_ROT_S_EOI, 3'h6);
		ack(8'h41);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_ROT_NS_EOI, 3'h5);
		raise(16'h0009);
		ack(8'h43);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NOP, 3'h3);
		quiet();
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_S_EOI, 3'h3);
		ack(8'h40);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
	endtask
	task automatic t_auto;
		cpc_host_inst.init(mc, 5'h08, 2'h1);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_ROT_AUTO_END_OF_INTERRUPT_SET, 3'h0);
		raise(16'h0020);
		ack(8'h45);
		raise(16'h0042);
		ack(8'h46);
		ack(8'h41);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_ROT_AUTO_END_OF_INTERRUPT_CLR, 3'h0);
		raise(16'h0020);
		ack(8'h45);
		raise(16'h0048);
		ack(8'h43);
		ack(8'h46);
	endtask
	task automatic t_nested;
		cpc_host_inst.init(mc, 5'h08, 2'h2);
		cpc_host_inst.rd(md, r);
		chk(r, cpc_pkg::MASK_RESET);
		raise(16'h0008);
		ack(8'h43);
		raise(16'h0008);
		ack(8'h43);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
	endtask
	task automatic t_sysreset;
		cpc_host_inst.wr(md, 8'hFF);
		@(negedge clk);
		irq = 16'h0000;
		sys_rst = 1'b1;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		cpc_host_inst.rd(md, r);
		chk(r, cpc_pkg::MASK_RESET);
		raise(16'h0009);
		ack(8'h00);
		raise(16'h0001);
		quiet();
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
		ack(8'h00);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
		ack(8'h03);
		cpc_host_inst.cmd(mc, cpc_pkg::CMD_NS_EOI, 3'h0);
	endtask
	task automatic end_of_test;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		irq = 16'h0000;
		inta_req = 1'b0;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_init();
		t_mask();
		t_rotate();
		t_auto();
		t_nested();
		t_sysreset();
		end_of_test();
	end
	// whole run is a few hundred cycles, far below the 10000-cycle timeout
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end
endmodule
